/* File: hw/ssi_cfg_pkg.sv */
// package: register layout, reset values and timing for the serial slave config
`default_nettype none
package ssi_cfg_pkg;
   // register indices inside the block's own small register port
   localparam logic [1:0] idx_timeout_ctl = 2'h0;
   localparam logic [1:0] idx_global_cfg = 2'h1;
   localparam logic [1:0] idx_status = 2'h2;
   localparam logic [1:0] idx_addr_cfg = 2'h3;
   // reset values
   localparam logic [7:0] rst_timeout_ctl = 8'h79;
   localparam logic [7:0] rst_global_cfg = 8'h01;
   localparam logic [7:0] rst_status = 8'h00;
   localparam logic [6:0] rst_dev_addr = 7'h09;
   // field positions
   localparam int data_en_bit = 6;
   localparam int resv_check_bit = 5;
   localparam int limit_msb = 4;
   localparam int drive_lsb = 3;
   localparam int addr_size_bit = 2;
   localparam int clock_flag_bit = 0;
   localparam int data_flag_bit = 1;
   localparam logic [1:0] drive_reserved = 2'h2;
   // timing
   localparam int clk_mhz = 200;
   localparam int ms_in_us = 1000;
   localparam int cycles_per_ms = clk_mhz * ms_in_us;

   typedef enum logic [1:0] {
      mode_off = 2'b00,
      mode_i2c = 2'b01,
      mode_spi = 2'b10,
      mode_smbus = 2'b11
   } slave_mode_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] idx;
      logic [7:0] wdata;
   } reg_req_s;
endpackage
`default_nettype wire

/* File: hw/ssi_cfg.sv */
// serial slave mode, addressing, drive strength and SMBus timeout checks
//
// Operation
// - data timeout check sets data flag when enabled
// - five-bit millisecond limit, zero stops clock check
// - clock timeout sets status bit zero
// - flags sticky, reset zero, cleared writing one
// - two-bit mode selects which protocol responds
// - one or two address bytes per size bit
// - page register above received bytes, 32 bits
// - drive strength only in I2C/SMBus mode
// - respond only to matching seven-bit address
`timescale 1ns/10ps
`default_nettype none
module ssi_cfg
   import ssi_cfg_pkg::*;
#(
   parameter int unsigned cyc_per_ms = cycles_per_ms
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire reg_req_s req,
   output logic [7:0] rdata,
   // bus pins
   input wire logic scl_pin,
   input wire logic data_or_select_pin,
   // engine side
   input wire logic [31:8] page_reg,
   input wire logic [15:0] rx_addr_bytes,
   input wire logic [6:0] rx_target_addr,
   output logic [31:0] full_addr,
   output logic [1:0] addr_bytes,
   output logic addr_match,
   output logic i2c_on,
   output logic spi_on,
   output logic smbus_on,
   output logic [1:0] pad_drive,
   output logic pad_drive_en
);
   // register state
   logic [7:0] ctl_ff, nxt_ctl;
   logic [7:0] gcfg_ff, nxt_gcfg;
   logic [1:0] sts_ff, nxt_sts;
   logic [6:0] dev_addr_ff, nxt_dev_addr;
   // bus activity and timeout state
   logic [1:0] pin_in, pin_lvl, pin_edge;
   logic [31:0] sub_ff, nxt_sub;
   logic [4:0] ms_clk_ff, nxt_ms_clk;
   logic [4:0] ms_dat_ff, nxt_ms_dat;
   logic [7:0] rdata_ff, nxt_rdata;
   logic scl_edge, sda_edge, smb_mode, tick, clk_to, dat_to;
   logic clk_chk_on, dat_chk_on;
   logic [4:0] limit;
   slave_mode_e mode;

   // one strobe decoder shared by all writable registers
   function automatic logic wr_hit(input reg_req_s r, input logic [1:0] i);
      wr_hit = r.wr && (r.idx == i);
   endfunction

   assign mode = slave_mode_e'(gcfg_ff[1:0]);
   assign smb_mode = (mode == mode_smbus);
   // one limit serves both the clock and the data check
   assign limit = ctl_ff[limit_msb:0];

   // two flops per pin before any logic looks; edges are taken between
   // the second and third stage so the first stage is never read
   assign pin_in = {data_or_select_pin, scl_pin};
   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [2:0] sync_ff, nxt_sync;
      always_comb begin
         nxt_sync = {sync_ff[1:0], pin_in[g]};
      end
      // reset to the pulled-up idle level, so no false edge after reset
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            sync_ff <= 3'h7;
         end else begin
            sync_ff <= nxt_sync;
         end
      end
      assign pin_lvl[g] = sync_ff[2];
      assign pin_edge[g] = sync_ff[2] ^ sync_ff[1];
   end
   // bit 0 carries the clock pin, bit 1 the data pin
   assign scl_edge = pin_edge[0];
   assign sda_edge = pin_edge[1];

   // register writes; reserved bits are dropped so they read back zero
   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_gcfg = gcfg_ff;
      nxt_dev_addr = dev_addr_ff;
      if (wr_hit(req, idx_timeout_ctl)) begin
         nxt_ctl = {1'b0, req.wdata[6:0]};
      end
      if (wr_hit(req, idx_global_cfg)) begin
         nxt_gcfg = {3'h0, req.wdata[4:0]};
      end
      // device address, compared here with rx_target_addr and reported to the engine through addr_match
      if (wr_hit(req, idx_addr_cfg)) begin
         nxt_dev_addr = req.wdata[6:0];
      end
   end

   // zero duration stops both checks, so a zero limit can never leave
   // the data check running on its own
   assign clk_chk_on = (limit != 5'h0);
   assign dat_chk_on = clk_chk_on && ctl_ff[data_en_bit];

   // timeout counters, restarted on any bus edge
   always_comb begin
      nxt_sub = sub_ff;
      nxt_ms_clk = ms_clk_ff;
      nxt_ms_dat = ms_dat_ff;
      tick = 1'b0;
      // held at zero outside SMBus or with the check off, so a later
      // enable always starts a full stretch
      if (!smb_mode || !clk_chk_on || scl_edge || sda_edge) begin
         nxt_sub = 32'h0;
         nxt_ms_clk = 5'h0;
         nxt_ms_dat = 5'h0;
      end else if (sub_ff == 32'(cyc_per_ms - 1)) begin
         // sub spans one millisecond of system clocks
         nxt_sub = 32'h0;
         tick = 1'b1;
      end else begin
         nxt_sub = sub_ff + 32'h1;
      end
      // counts stop at the limit; a limit lowered mid-stretch must not
      // let them wrap and fire a second time
      if (tick && clk_chk_on && ms_clk_ff < limit) begin
         nxt_ms_clk = ms_clk_ff + 5'h1;
      end
      if (tick && dat_chk_on && ms_dat_ff < limit) begin
         nxt_ms_dat = ms_dat_ff + 5'h1;
      end
   end
   // clock stall: scl held low; data stall: sda held low
   assign clk_to = tick && clk_chk_on && !pin_lvl[0]
                   && ms_clk_ff == limit - 5'h1;
   assign dat_to = tick && dat_chk_on && !pin_lvl[1]
                   && ms_dat_ff == limit - 5'h1;

   // status: set beats write-one clear
   // a clear landing with a new timeout loses, so no event is missed
   always_comb begin
      nxt_sts = sts_ff;
      if (wr_hit(req, idx_status)) begin
         nxt_sts = sts_ff & ~req.wdata[1:0];
      end
      if (clk_to) begin
         nxt_sts[clock_flag_bit] = 1'b1;
      end
      if (dat_to) begin
         nxt_sts[data_flag_bit] = 1'b1;
      end
   end

   // read data is registered and holds until the next read
   always_comb begin
      nxt_rdata = 8'h00;
      if (req.rd) begin
         case (req.idx)
            idx_timeout_ctl: nxt_rdata = ctl_ff;
            idx_global_cfg: nxt_rdata = gcfg_ff;
            idx_status: nxt_rdata = {6'h0, sts_ff};
            idx_addr_cfg: nxt_rdata = {1'b0, dev_addr_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end else begin
         nxt_rdata = rdata_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // the config register reset values come from the package; counters and read data reset to zero
         ctl_ff <= rst_timeout_ctl;
         gcfg_ff <= rst_global_cfg;
         sts_ff <= rst_status[1:0];
         dev_addr_ff <= rst_dev_addr;
         sub_ff <= 32'h0;
         ms_clk_ff <= 5'h0;
         ms_dat_ff <= 5'h0;
         rdata_ff <= 8'h00;
      end else begin
         ctl_ff <= nxt_ctl;
         gcfg_ff <= nxt_gcfg;
         sts_ff <= nxt_sts;
         dev_addr_ff <= nxt_dev_addr;
         sub_ff <= nxt_sub;
         ms_clk_ff <= nxt_ms_clk;
         ms_dat_ff <= nxt_ms_dat;
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata = rdata_ff;

   // mode decode
   // only the selected protocol's engine may answer on the pins
   assign i2c_on = (mode == mode_i2c);
   assign spi_on = (mode == mode_spi);
   assign smbus_on = smb_mode;
   // address bytes the engine must collect before a register access
   assign addr_bytes = gcfg_ff[addr_size_bit] ? 2'h2 : 2'h1;
   // one-byte mode ignores the upper received byte
   assign full_addr = gcfg_ff[addr_size_bit] ?
      {page_reg[31:16], rx_addr_bytes} :
      {page_reg[31:8], rx_addr_bytes[7:0]};
   assign addr_match = (i2c_on || smb_mode)
                       && rx_target_addr == dev_addr_ff;
   // pad setting only; internal timing untouched
   // the reserved code passes through as written; software avoids it
   assign pad_drive_en = i2c_on || smb_mode;
   assign pad_drive = pad_drive_en ? gcfg_ff[drive_lsb +: 2] : 2'h0;
endmodule
`default_nettype wire

/* File: sim/ssi_cfg_asserts.sv */
// checker: mode, pad and address relations at the ssi_cfg ports
`timescale 1ns/10ps
`default_nettype none
module ssi_cfg_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // addressing and modes
   input wire logic [31:8] page_reg,
   input wire logic [15:0] rx_addr_bytes,
   input wire logic [31:0] full_addr,
   input wire logic [1:0] addr_bytes,
   input wire logic addr_match,
   input wire logic i2c_on,
   input wire logic spi_on,
   input wire logic smbus_on,
   input wire logic [1:0] pad_drive,
   input wire logic pad_drive_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_one_mode: assert property ($onehot0({i2c_on, spi_on, smbus_on}))
      else $error("modes");
   a_pad_off: assert property (!pad_drive_en |-> pad_drive == 2'h0)
      else $error("pad off");
   a_pad_i2c: assert property (i2c_on |-> pad_drive_en)
      else $error("pad i2c");
   a_pad_smb: assert property (smbus_on |-> pad_drive_en)
      else $error("pad smbus");
   a_spi_quiet: assert property (spi_on |-> !pad_drive_en)
      else $error("spi pads");
   a_match_mode: assert property (addr_match |-> i2c_on || smbus_on)
      else $error("match");
   a_bytes_legal: assert property (addr_bytes == 2'h1 || addr_bytes == 2'h2)
      else $error("address byte count");
   a_addr_one: assert property (addr_bytes == 2'h1 |->
      full_addr == {page_reg, rx_addr_bytes[7:0]}) else $error("addr1");
   a_addr_two: assert property (addr_bytes == 2'h2 |->
      full_addr == {page_reg[31:16], rx_addr_bytes}) else $error("addr2");
endmodule
`default_nettype wire

/* File: sim/bus_master_model.sv */
// far-side master: clock only in frames, pins pulled high when released
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
   // bench control
   input wire logic run,
   input wire logic stall,
   // bus pins
   output logic scl,
   output logic sda
);
   logic tick = 1'b1;
   always #80 tick = ~tick;
   assign scl = run ? tick : !stall;
   assign sda = !stall;
endmodule
`default_nettype wire

/* File: sim/ssi_cfg_tb.sv */
// bench: registers, modes, addressing and timeouts of ssi_cfg
`timescale 1ns/10ps
`default_nettype none
module ssi_cfg_tb import ssi_cfg_pkg::*; ;
   logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, stall = 1'b0;
   reg_req_s req = '0;
   logic [31:8] page_reg = 24'habcdef;
   logic [15:0] rx_addr_bytes = 16'h1234;
   logic [6:0] rx_target_addr = 7'h09;
   logic [31:0] full_addr;
   logic [7:0] rdata;
   logic [1:0] addr_bytes, pad_drive;
   logic scl, sda, addr_match, i2c_on, spi_on, smbus_on, pad_drive_en;
   int fails = 0, checked = 0, cyc = 0;
   always #2.5 clk = ~clk;
   bus_master_model far (.run, .stall, .scl, .sda);
   // short millisecond keeps the timeout runs brief
   ssi_cfg #(.cyc_per_ms(10)) dut (.clk, .rst_b, .req, .rdata,
      .scl_pin(scl), .data_or_select_pin(sda), .page_reg, .rx_addr_bytes,
      .rx_target_addr, .full_addr, .addr_bytes, .addr_match, .i2c_on,
      .spi_on, .smbus_on, .pad_drive, .pad_drive_en);
   task automatic ck(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [1:0] i, input logic [7:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, i, d};
      @(posedge clk) req <= '0;
      #1;
   endtask
   task automatic rd(input logic [1:0] i, input logic [7:0] e);
      @(posedge clk) req <= '{1'b0, 1'b1, i, 8'h00};
      @(posedge clk) req <= '0;
      #1 ck("rdata", {24'h0, e}, {24'h0, rdata});
   endtask
   task automatic addr(input logic [7:0] c, input logic [34:0] e);
      wr(idx_global_cfg, c);
      ck("addr", e[34:3], full_addr);
      ck("bytes_match", {29'h0, e[2:0]},
         {29'h0, addr_bytes, addr_match});
   endtask
   task automatic pins(input logic r, s);
      @(posedge clk) {run, stall} <= {r, s};
      repeat (40) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(idx_timeout_ctl, 8'h79);
      rd(idx_global_cfg, 8'h01);
      rd(idx_status, 8'h00);
      rd(idx_addr_cfg, 8'h09);
      $display("reset values done");
      for (int m = 0; m < 4; m++) begin
         wr(idx_global_cfg, 8'hf8 | 8'(m));
         ck("mode_pads", {26'h0, m == 1, m == 2, m == 3, {3{m[0]}}},
            {26'h0, i2c_on, spi_on, smbus_on, pad_drive_en, pad_drive});
      end
      rd(idx_global_cfg, 8'h1b);
      $display("modes done");
      addr(8'h07, {32'habcd1234, 3'b101});
      addr(8'h01, {32'habcdef34, 3'b011});
      addr(8'h02, {32'habcdef34, 3'b010});
      wr(idx_addr_cfg, 8'h0a);
      addr(8'h01, {32'habcdef34, 3'b010});
      $display("addressing done");
      wr(idx_global_cfg, 8'h03);
      wr(idx_timeout_ctl, 8'hff);
      rd(idx_timeout_ctl, 8'h7f);
      wr(idx_timeout_ctl, 8'h42);
      pins(1'b1, 1'b0);
      pins(1'b1, 1'b0);
      rd(idx_status, 8'h00);
      pins(1'b0, 1'b1);
      rd(idx_status, 8'h03);
      wr(idx_status, 8'h01);
      rd(idx_status, 8'h02);
      pins(1'b0, 1'b0);
      wr(idx_status, 8'h02);
      rd(idx_status, 8'h00);
      // data check off, clock check still on
      wr(idx_timeout_ctl, 8'h02);
      pins(1'b0, 1'b1);
      rd(idx_status, 8'h01);
      pins(1'b0, 1'b0);
      wr(idx_status, 8'h01);
      wr(idx_timeout_ctl, 8'h00);
      pins(1'b0, 1'b1);
      rd(idx_status, 8'h00);
      $display("timeouts done");
      print_verdict();
   end
endmodule
bind ssi_cfg ssi_cfg_asserts chk (.clk, .rst_b, .page_reg, .rx_addr_bytes,
   .full_addr, .addr_bytes, .addr_match, .i2c_on, .spi_on, .smbus_on,
   .pad_drive, .pad_drive_en);
`default_nettype wire
